/* File: bench/test_superscalar_pipeline_control.sv */
`timescale 1ns/100ps
module test_superscalar_pipeline_control;
  import spc_pkg::*;
  logic             clk_i          = 1'b0;
  logic             arst_n_i       = 1'b0;
  logic             icache_valid_i = 1'b0;
  logic [IW-1:0]    icache_instr_i = 16'h0000;
  logic [NU-1:0]    unit_ready_i   = 6'h3f;
  logic             fin_valid_i    = 1'b0;
  logic             fin_excp_i     = 1'b0;
  logic             fin_mispred_i  = 1'b0;
  logic             fin_direct_i   = 1'b0;
  logic [TW-1:0]    fin_tag_i      = 3'h0;
  logic [DW-1:0]    fin_data_i     = 16'h0000;
  logic             fetch_req_o, flush_o, commit_o, wb_valid_o, direct_valid_o;
  logic [PW-1:0]    fetch_pc_o;
  logic [NU-1:0]    ex_valid_o;
  logic [NU*TW-1:0] ex_tag_o;
  logic [NU*8-1:0]  ex_imm_o;
  logic [TW-1:0]    commit_tag_o, wb_tag_o;
  logic [DW-1:0]    wb_data_o, direct_data_o, cond_reg_o, loop_count_o, link_reg_o;
  int               errors  = 0;
  int               n_tests = 0;
  int               cyc     = 0;
  logic [TW-1:0]    exp_tag;
  logic [PW-1:0]    exp_pc;
  logic [DW-1:0]    e_cond, e_loop, e_link;
  // Multiply, divide (also by zero), special-register, float add and float divide.
  logic [15:0]      tab [7] = '{16'hd302, 16'hd30a, 16'h900a, 16'h5a42, 16'h7803, 16'h780b, 16'hff02};

  spc_pipe_ctrl i_spc_pipe_ctrl (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .icache_valid_i(icache_valid_i), .icache_instr_i(icache_instr_i),
    .fetch_req_o(fetch_req_o), .fetch_pc_o(fetch_pc_o), .unit_ready_i(unit_ready_i),
    .ex_valid_o(ex_valid_o), .ex_tag_o(ex_tag_o), .ex_imm_o(ex_imm_o),
    .fin_valid_i(fin_valid_i), .fin_tag_i(fin_tag_i), .fin_data_i(fin_data_i), .fin_excp_i(fin_excp_i),
    .fin_mispred_i(fin_mispred_i), .fin_direct_i(fin_direct_i), .flush_o(flush_o), .commit_o(commit_o),
    .commit_tag_o(commit_tag_o), .wb_valid_o(wb_valid_o), .wb_tag_o(wb_tag_o), .wb_data_o(wb_data_o),
    .direct_valid_o(direct_valid_o), .direct_data_o(direct_data_o), .cond_reg_o(cond_reg_o),
    .loop_count_o(loop_count_o), .link_reg_o(link_reg_o)
  );

  always #5 clk_i = ~clk_i;

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Serial traffic needs well under a tenth of this; reaching it means a hang.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic int unit_of(input logic [15:0] ins);
    return (ins[2:0] > 3'h5) ? 5 : int'(ins[2:0]);
  endfunction

  function automatic logic [15:0] result_of(input logic [15:0] ins, input logic [15:0] fd);
    logic [15:0] a;
    logic [15:0] b;
    a = {12'h000, ins[15:12]};
    b = {12'h000, ins[11:8]};
    if (unit_of(ins) == 2 && ins[F_SPR]) return {8'h00, ins[15:8]};
    if (unit_of(ins) == 2 && ins[F_DIV]) return (b == 16'h0000) ? 16'h0000 : a / b;
    if (unit_of(ins) == 2) return a * b;
    if (unit_of(ins) == 3) return a + b;
    return fd;
  endfunction

  task automatic issue(input logic [15:0] ins, input int stall, output logic [2:0] tg);
    int u;
    int k;
    u = unit_of(ins);
    if (u == 2 || u == 3) stall = 0;
    if (stall > 0) unit_ready_i[u] = 1'b0;
    k = 0;
    while (fetch_req_o !== 1'b1 && k < 30) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    chk("fetch_pc", exp_pc, fetch_pc_o);
    icache_valid_i = 1'b1;
    icache_instr_i = ins;
    @(posedge clk_i);
    #1;
    chk("fetch_req_drop", 16'h0000, 16'(fetch_req_o));
    icache_valid_i = 1'b0;
    icache_instr_i = 16'($urandom);
    exp_pc = exp_pc + PC_STEP;
    for (k = 0; k < stall; k++) begin
      @(posedge clk_i);
      #1;
      chk("held_issue", 16'h0000, 16'(ex_valid_o[u]));
    end
    unit_ready_i[u] = 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      #1;
      k++;
    end while (ex_valid_o[u] !== 1'b1 && k < 30);
    chk("issue", 16'h0001, 16'(ex_valid_o[u]));
    chk("issue_tag", 16'(exp_tag), 16'(ex_tag_o[3*u +: 3]));
    chk("issue_imm", 16'(ins[15:8]), 16'(ex_imm_o[8*u +: 8]));
    tg = exp_tag;
    exp_tag++;
  endtask

  task automatic fin(input logic [2:0] tg, input logic [15:0] d, input logic ex, mi, di);
    fin_valid_i = 1'b1;
    fin_tag_i = tg;
    fin_data_i = d;
    fin_excp_i = ex;
    fin_mispred_i = mi;
    fin_direct_i = di;
    @(posedge clk_i);
    #1;
    fin_valid_i = 1'b0;
    fin_excp_i = 1'b0;
    fin_mispred_i = 1'b0;
    fin_direct_i = 1'b0;
    fin_data_i = 16'($urandom);
  endtask

  task automatic expect_done(input logic [2:0] tg, input logic [15:0] ins, d, input logic ex, mi, di);
    logic sc, sf, sw, sd;
    logic [15:0] r;
    sc = 1'b0;
    sf = 1'b0;
    sw = 1'b0;
    sd = 1'b0;
    r = result_of(ins, d);
    // The bypass pulse stands only in the cycle right after the finish edge, before the first loop sample.
    if (direct_valid_o === 1'b1) begin
      sd = 1'b1;
      chk("direct_data", r, direct_data_o);
    end
    for (int k = 0; k < 40 && !sc && !sf; k++) begin
      @(posedge clk_i);
      #1;
      if (wb_valid_o === 1'b1) begin
        sw = 1'b1;
        chk("wb_tag", 16'(tg), 16'(wb_tag_o));
        chk("wb_data", r, wb_data_o);
      end
      if (direct_valid_o === 1'b1) begin
        sd = 1'b1;
        chk("direct_data", r, direct_data_o);
      end
      if (commit_o === 1'b1) begin
        sc = 1'b1;
        chk("commit_tag", 16'(tg), 16'(commit_tag_o));
      end
      sf = (flush_o === 1'b1);
    end
    if (ex || mi) begin
      chk("flush", 16'h0001, 16'(sf));
      chk("cancelled_commit", 16'h0000, 16'(sc));
      exp_pc = ex ? EXC_VEC : d;
      exp_tag = 3'h0;
      @(posedge clk_i);
      #1;
      chk("redirect_pc", exp_pc, fetch_pc_o);
    end else begin
      chk("commit", 16'h0001, 16'(sc));
      case (ins[5:4])
        2'h1: e_cond = r;
        2'h2: e_loop = r;
        2'h3: e_link = r;
        default: ;
      endcase
      chk("writeback", 16'(ins[5:4] == 2'h0 && !di), 16'(sw));
      chk("direct", 16'(di), 16'(sd));
    end
    chk("cond_reg", e_cond, cond_reg_o);
    chk("loop_count", e_loop, loop_count_o);
    chk("link_reg", e_link, link_reg_o);
  endtask

  task automatic run_op(input logic [15:0] ins, d, input logic ex, mi, di, input int stall);
    logic [2:0] tg;
    issue(ins, stall, tg);
    if (unit_of(ins) == 2 || unit_of(ins) == 3) begin
      ex = 1'b0;
      mi = 1'b0;
      di = 1'b0;
    end else begin
      fin(tg, d, ex, mi, di);
    end
    expect_done(tg, ins, d, ex, mi, di);
  endtask

  initial begin
    logic [2:0] ta, tb;
    logic [15:0] ins, d;
    int r;
    void'($urandom(9304));
    exp_tag = 3'h0;
    exp_pc = PC_RST;
    e_cond = REG_RST;
    e_loop = REG_RST;
    e_link = REG_RST;
    repeat (6) @(posedge clk_i);
    #1;
    chk("reset_pc", PC_RST, fetch_pc_o);
    chk("reset_commit", 16'h0000, 16'(commit_o));
    chk("reset_cond", REG_RST, cond_reg_o);
    arst_n_i = 1'b1;
    for (int s = 1; s < 4; s++) run_op({8'h3c, 2'b00, 2'(s), 1'b0, U_SC1}, 16'($urandom), 0, 0, 0, 0);
    run_op({8'h77, 4'h0, 1'b0, U_SC0}, 16'hbeef, 0, 0, 1, 0);
    run_op({8'h12, 4'h0, 1'b0, U_LS}, 16'h4321, 0, 0, 0, 6);
    foreach (tab[i]) run_op(tab[i], 16'h0000, 0, 0, 0, 0);
    issue({8'h11, 4'h0, 1'b0, U_SC0}, 0, ta);
    issue({8'h22, 4'h0, 1'b0, U_SC1}, 0, tb);
    fin(tb, 16'h2222, 0, 0, 0);
    repeat (4) begin
      @(posedge clk_i);
      #1;
      chk("early_commit", 16'h0000, 16'(commit_o));
    end
    fin(ta, 16'h1111, 0, 0, 0);
    expect_done(ta, {8'h11, 4'h0, 1'b0, U_SC0}, 16'h1111, 0, 0, 0);
    expect_done(tb, {8'h22, 4'h0, 1'b0, U_SC1}, 16'h2222, 0, 0, 0);
    run_op({8'h02, 2'b00, 2'b01, 1'b0, U_SC0}, 16'hffff, 1, 0, 0, 0);
    run_op({8'h05, 4'h0, 1'b0, U_BR}, 16'h0a40, 0, 1, 0, 0);
    for (int n = 0; n < 48; n++) begin
      ins = 16'($urandom);
      d = 16'($urandom);
      r = $urandom % 8;
      if (r == 1) d[1:0] = 2'b00;
      run_op(ins, d, r == 0, r == 1, r == 2 && ins[5:4] == 2'h0, ($urandom % 4 == 0) ? 3 : 0);
    end
    close_out();
  end
endmodule

/* File: verilog/spc_pipe_ctrl.sv */
`timescale 1ns/100ps
module spc_pipe_ctrl (
  input  wire logic                          clk_i,
  input  wire logic                          arst_n_i,
  input  wire logic                          icache_valid_i,
  input  wire logic [spc_pkg::IW-1:0]        icache_instr_i,
  output logic                               fetch_req_o,
  output logic [spc_pkg::PW-1:0]             fetch_pc_o,
  input  wire logic [spc_pkg::NU-1:0]        unit_ready_i,
  output logic [spc_pkg::NU-1:0]             ex_valid_o,
  output logic [spc_pkg::NU*spc_pkg::TW-1:0] ex_tag_o,
  output logic [spc_pkg::NU*8-1:0]           ex_imm_o,
  input  wire logic                          fin_valid_i,
  input  wire logic [spc_pkg::TW-1:0]        fin_tag_i,
  input  wire logic [spc_pkg::DW-1:0]        fin_data_i,
  input  wire logic                          fin_excp_i,
  input  wire logic                          fin_mispred_i,
  input  wire logic                          fin_direct_i,
  output logic                               flush_o,
  output logic                               commit_o,
  output logic [spc_pkg::TW-1:0]             commit_tag_o,
  output logic                               wb_valid_o,
  output logic [spc_pkg::TW-1:0]             wb_tag_o,
  output logic [spc_pkg::DW-1:0]             wb_data_o,
  output logic                               direct_valid_o,
  output logic [spc_pkg::DW-1:0]             direct_data_o,
  output logic [spc_pkg::DW-1:0]             cond_reg_o,
  output logic [spc_pkg::DW-1:0]             loop_count_o,
  output logic [spc_pkg::DW-1:0]             link_reg_o
);
  import spc_pkg::*;

  typedef struct packed {
    spc_cs_type                  cs;
    logic                        fr;
    logic [PW-1:0]               pc;
    logic                        dq_v;
    logic [IW-1:0]               dq;
    logic                        sq_v;
    logic [IW-1:0]               sq;
    logic [ENT_N-1:0]            rv;
    logic [ENT_N-1:0]            rd;
    logic [ENT_N-1:0]            rx;
    logic [ENT_N-1:0]            rm;
    logic [ENT_N-1:0]            rw;
    logic [ENT_N-1:0][1:0]       rs;
    logic [ENT_N-1:0][DW-1:0]    rb;
    logic [TW-1:0]               hd;
    logic [TW-1:0]               tl;
    logic [TW:0]                 cnt;
    logic [NU-1:0]               qv;
    logic [NU-1:0][TW-1:0]       qt;
    logic [NU-1:0][7:0]          qi;
    logic [NU-1:0]               ev;
    logic [NU-1:0][TW-1:0]       et;
    logic [NU-1:0][7:0]          ei;
    logic                        m1v;
    logic                        m1d;
    logic [TW-1:0]               m1t;
    logic [7:0]                  m1i;
    logic                        m2v;
    logic                        m2d;
    logic [TW-1:0]               m2t;
    logic [7:0]                  m2i;
    logic [3:0]                  mc;
    logic                        m3v;
    logic [TW-1:0]               m3t;
    logic [DW-1:0]               m3r;
    logic                        pv;
    logic [TW-1:0]               pt;
    logic [7:0]                  pi;
    logic                        f1v;
    logic                        f1d;
    logic [TW-1:0]               f1t;
    logic [7:0]                  f1i;
    logic [3:0]                  fc;
    logic                        f2v;
    logic [TW-1:0]               f2t;
    logic [DW-1:0]               f2r;
    logic                        f3v;
    logic [TW-1:0]               f3t;
    logic [DW-1:0]               f3r;
    logic                        fl;
    logic                        cm;
    logic [TW-1:0]               ct;
    logic                        wbv;
    logic [TW-1:0]               wbt;
    logic [DW-1:0]               wbd;
    logic                        dv;
    logic [DW-1:0]               dd;
    logic [DW-1:0]               cnd;
    logic [DW-1:0]               lpc;
    logic [DW-1:0]               lnk;
  } spc_st_type;

  spc_st_type    q;
  spc_st_type    n;
  logic          ret;
  logic          flu;
  logic          disp;
  logic          dec;
  logic          fet;
  logic          ok;
  logic          spr;
  logic          m2_hold;
  logic          m1_go;
  logic          m_acc;
  logic          f1_hold;
  logic          f1_go;
  logic [2:0]    du;
  logic [2:0]    dcu;
  logic [TW-1:0] tg;

  always_comb begin
    n       = q;
    n.fl    = 1'b0;
    n.cm    = 1'b0;
    n.wbv   = 1'b0;
    n.dv    = 1'b0;
    n.ev    = '0;
    // Completion looks only at the head, so nothing younger can retire first.
    ret     = q.rv[q.hd] && q.rd[q.hd];
    flu     = ret && (q.rx[q.hd] || q.rm[q.hd]);
    m2_hold = q.m2v && q.m2d && (q.mc != 4'h0);
    m1_go   = q.m1v && !m2_hold;
    m_acc   = !q.m1v || m1_go;
    f1_hold = q.f1v && q.f1d && (q.fc != 4'h0);
    f1_go   = q.f1v && !f1_hold;
    du      = q.sq[F_UNIT+:3];
    spr     = q.sq[F_SPR];
    tg      = q.tl;
    case (du)
      U_MC:    ok = spr || m_acc;
      U_FP:    ok = !f1_hold;
      default: ok = !q.qv[du];
    endcase
    // Entries are allocated in the same cycle that an instruction is issued or queued to a unit.
    disp = q.sq_v && (q.cnt < 4'(ENT_N)) && ok && !flu;
    dec  = q.dq_v && (!q.sq_v || disp);
    fet  = q.fr && icache_valid_i && (!q.dq_v || dec);
    dcu  = (q.dq[F_UNIT+:3] > U_LS) ? U_LS : q.dq[F_UNIT+:3];

    // Fetch stage.
    if (fet) begin
      n.dq_v = 1'b1;
      n.dq   = icache_instr_i;
      n.pc   = q.pc + PC_STEP;
    end else if (dec) begin
      n.dq_v = 1'b0;
    end
    // Decode: only the unit steering is resolved here.
    if (dec) begin
      n.sq_v = 1'b1;
      n.sq   = {q.dq[IW-1:3], dcu};
    end else if (disp) begin
      n.sq_v = 1'b0;
    end

    // Stations hand a waiting entry to a unit that reports ready.
    for (int u = 0; u < NU; u++) begin
      if (q.qv[u] && unit_ready_i[u]) begin
        n.ev[u] = 1'b1;
        n.et[u] = q.qt[u];
        n.ei[u] = q.qi[u];
        n.qv[u] = 1'b0;
      end
    end

    // Multiplier stages three and two.
    n.m3v = q.m2v && !m2_hold;
    n.m3t = q.m2t;
    n.m3r = q.m2d ? ((q.m2i[3:0] == 4'h0) ? REG_RST : DW'(q.m2i[7:4] / q.m2i[3:0]))
                  : DW'(q.m2i[7:4] * q.m2i[3:0]);
    if (m2_hold) begin
      n.mc = q.mc - 4'h1;
    end
    if (m1_go) begin
      n.m2v = 1'b1;
      n.m2d = q.m1d;
      n.m2t = q.m1t;
      n.m2i = q.m1i;
      n.mc  = q.m1d ? DIV_ITER : 4'h0;
    end else if (!m2_hold) begin
      n.m2v = 1'b0;
    end
    if (m1_go) begin
      n.m1v = 1'b0;
    end
    n.pv = 1'b0;
    // Floating point stages three and two.
    n.f3v = q.f2v;
    n.f3t = q.f2t;
    n.f3r = q.f2r;
    n.f2v = f1_go;
    n.f2t = q.f1t;
    n.f2r = DW'(q.f1i[7:4] + q.f1i[3:0]);
    if (f1_hold) begin
      n.fc = q.fc - 4'h1;
    end else if (f1_go) begin
      n.f1v = 1'b0;
    end

    // Dispatch: finish decode, allocate, then issue.
    if (disp) begin
      n.rv[tg] = 1'b1;
      n.rd[tg] = 1'b0;
      n.rx[tg] = 1'b0;
      n.rm[tg] = 1'b0;
      n.rw[tg] = 1'b0;
      n.rs[tg] = q.sq[F_SPEC+:2];
      n.tl     = q.tl + 3'h1;
      n.et[du] = tg;
      n.ei[du] = q.sq[F_IMM+:8];
      if (du == U_MC && spr) begin
        n.pv = 1'b1;
        n.pt = tg;
        n.pi = q.sq[F_IMM+:8];
        n.ev[du] = 1'b1;
      end else if (du == U_MC) begin
        n.m1v = 1'b1;
        n.m1d = q.sq[F_DIV];
        n.m1t = tg;
        n.m1i = q.sq[F_IMM+:8];
        n.ev[du] = 1'b1;
      end else if (du == U_FP) begin
        n.f1v = 1'b1;
        n.f1d = q.sq[F_DIV];
        n.f1t = tg;
        n.f1i = q.sq[F_IMM+:8];
        n.fc  = q.sq[F_DIV] ? FDIV_ITER : 4'h0;
        n.ev[du] = 1'b1;
      end else if (unit_ready_i[du]) begin
        n.ev[du] = 1'b1;
      end else begin
        n.qv[du] = 1'b1;
        n.qt[du] = tg;
        n.qi[du] = q.sq[F_IMM+:8];
      end
    end

    // Finish: results land in the rename buffer and mark the entry done.
    if (q.m3v) begin
      n.rd[q.m3t] = 1'b1;
      n.rb[q.m3t] = q.m3r;
    end
    if (q.pv) begin
      n.rd[q.pt] = 1'b1;
      n.rb[q.pt] = {8'h00, q.pi};
    end
    if (q.f3v) begin
      n.rd[q.f3t] = 1'b1;
      n.rb[q.f3t] = q.f3r;
    end
    if (fin_valid_i) begin
      n.rd[fin_tag_i] = 1'b1;
      n.rb[fin_tag_i] = fin_data_i;
      n.rx[fin_tag_i] = fin_excp_i;
      n.rm[fin_tag_i] = fin_mispred_i;
      // Only the oldest entry may skip the rename buffer, else state would be imprecise.
      if (fin_direct_i && fin_tag_i == q.hd) begin
        n.rw[fin_tag_i] = 1'b1;
        n.dv            = 1'b1;
        n.dd            = fin_data_i;
      end
    end

    // Completion.
    if (ret && !flu) begin
      n.cm     = 1'b1;
      n.ct     = q.hd;
      n.rv[q.hd] = 1'b0;
      n.hd     = q.hd + 3'h1;
      case (spc_spec_type'(q.rs[q.hd]))
        SP_COND: n.cnd = q.rb[q.hd];
        SP_LOOP: n.lpc = q.rb[q.hd];
        SP_LINK: n.lnk = q.rb[q.hd];
        default: begin
          n.wbv = !q.rw[q.hd];
          n.wbt = q.hd;
          n.wbd = q.rb[q.hd];
        end
      endcase
    end
    n.cnt = q.cnt + {3'h0, disp} - {3'h0, ret && !flu};

    case (q.cs)
      CS_RUN:   n.cs = CS_RUN;
      CS_FLUSH: n.cs = CS_RUN;
      default:  n.cs = CS_RUN;
    endcase
    n.fr = !n.dq_v;
    // A cancel wipes every younger entry and all work in flight.
    if (flu) begin
      n.fl   = 1'b1;
      n.cs   = CS_FLUSH;
      n.fr   = 1'b0;
      n.pc   = q.rm[q.hd] ? q.rb[q.hd] : EXC_VEC;
      n.rv   = '0;
      n.hd   = '0;
      n.tl   = '0;
      n.cnt  = '0;
      n.dq_v = 1'b0;
      n.sq_v = 1'b0;
      n.qv   = '0;
      n.ev   = '0;
      n.m1v  = 1'b0;
      n.m2v  = 1'b0;
      n.m3v  = 1'b0;
      n.pv   = 1'b0;
      n.f1v  = 1'b0;
      n.f2v  = 1'b0;
      n.f3v  = 1'b0;
      n.dv   = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q    <= '0;
      q.pc <= PC_RST;
      q.cnd <= REG_RST;
      q.lpc <= REG_RST;
      q.lnk <= REG_RST;
    end else begin
      q <= n;
    end
  end

  assign fetch_req_o    = q.fr;
  assign fetch_pc_o     = q.pc;
  assign ex_valid_o     = q.ev;
  assign ex_tag_o       = q.et;
  assign ex_imm_o       = q.ei;
  assign flush_o        = q.fl;
  assign commit_o       = q.cm;
  assign commit_tag_o   = q.ct;
  assign wb_valid_o     = q.wbv;
  assign wb_tag_o       = q.wbt;
  assign wb_data_o      = q.wbd;
  assign direct_valid_o = q.dv;
  assign direct_data_o  = q.dd;
  assign cond_reg_o     = q.cnd;
  assign loop_count_o   = q.lpc;
  assign link_reg_o     = q.lnk;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  logic [TW-1:0] lct_q;
  logic          lseen_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lct_q   <= '0;
      lseen_q <= 1'b0;
    end else if (q.fl) begin
      lseen_q <= 1'b0;
    end else if (q.cm) begin
      lct_q   <= q.ct;
      lseen_q <= 1'b1;
    end
  end

  sequence s_mul_flow;
    q.m2v ##1 q.m3v;
  endsequence
  sequence s_fp_flow;
    q.f2v ##1 q.f3v;
  endsequence

  AST_IN_ORDER: assert property (q.cm && lseen_q && !q.fl |-> q.ct == lct_q + 3'h1)
    else $error("Retire tag out of program order.");
  AST_FLUSH_GAP: assert property (q.fl |-> !q.fr && !q.cm && q.cs == CS_FLUSH && q.rv == '0 ##1 q.fr && q.cs == CS_RUN)
    else $error("Flush did not cancel the window.");
  AST_ALLOC: assert property (disp |=> q.rv[$past(q.tl)] && !q.rd[$past(q.tl)])
    else $error("Dispatch did not allocate a reorder entry.");
  AST_MUL3: assert property (q.m1v && !q.m1d && !m2_hold && !flu |=> s_mul_flow)
    else $error("Multiply did not take three stages.");
  AST_DIV_ITER: assert property (m2_hold && !flu |=> q.m2v && q.mc == $past(q.mc) - 4'h1 && !q.m3v)
    else $error("Divide did not iterate in stage two.");
  AST_FP3: assert property (q.f1v && !f1_hold && !flu |=> s_fp_flow)
    else $error("Float op did not take three stages.");
  AST_FDIV: assert property (f1_hold && !flu |=> q.f1v && !q.f2v)
    else $error("Float divide left stage one early.");
  AST_WB: assert property (q.wbv |-> q.cm && q.wbt == q.ct)
    else $error("Writeback without completion.");
  AST_SPEC: assert property ($changed(q.cnd) || $changed(q.lpc) || $changed(q.lnk) |-> q.cm)
    else $error("Special register changed outside completion.");
  AST_FETCH: assert property (fet && !flu |=> q.pc == $past(q.pc) + PC_STEP && q.dq_v)
    else $error("Fetch did not advance the address.");
endmodule

/* File: verilog/spc_pkg.sv */
package spc_pkg;
  localparam int ENT_N  = 8;
  localparam int TW     = 3;
  localparam int DW     = 16;
  localparam int PW     = 16;
  localparam int IW     = 16;
  localparam int NU     = 6;
  // Unit numbers carried in the low instruction field.
  localparam logic [2:0] U_SC0 = 3'h0;
  localparam logic [2:0] U_SC1 = 3'h1;
  localparam logic [2:0] U_MC  = 3'h2;
  localparam logic [2:0] U_FP  = 3'h3;
  localparam logic [2:0] U_BR  = 3'h4;
  localparam logic [2:0] U_LS  = 3'h5;
  // Instruction field positions.
  localparam int F_UNIT = 0;
  localparam int F_DIV  = 3;
  localparam int F_SPEC = 4;
  localparam int F_SPR  = 6;
  localparam int F_IMM  = 8;
  // Reset values, fetch step and redirect target.
  localparam logic [PW-1:0] PC_RST  = 16'h0000;
  localparam logic [PW-1:0] PC_STEP = 16'h0004;
  localparam logic [PW-1:0] EXC_VEC = 16'h0100;
  localparam logic [DW-1:0] REG_RST = 16'h0000;
  // Iteration counts in cycles.
  localparam logic [3:0] DIV_ITER  = 4'h8;
  localparam logic [3:0] FDIV_ITER = 4'h6;

  typedef enum logic [1:0] {
    SP_NONE = 2'h0,
    SP_COND = 2'h1,
    SP_LOOP = 2'h2,
    SP_LINK = 2'h3
  } spc_spec_type;

  typedef enum logic [0:0] {
    CS_RUN   = 1'h0,
    CS_FLUSH = 1'h1
  } spc_cs_type;
endpackage
